// *** inc/oag_params.svh ***
// Constants for the operand address generator
// How it works
// - Compact base mode: displacement plus word register, register zero refused, data space.
// - Compact base and base-index modes accept only load and load-address.
// - Compact base-index: base register plus index register, no displacement, neither zero.
// - Compact relative mode adds displacement to low word of program counter only; call and decrement-jump-nonzero subtract it.
// - Relative modes use the address of the word after the displacement.
// - Compact relative mode accepts load, load-address, call, jump, decrement-jump-nonzero only.
// - Relative operands come from instruction memory space.
// - Relative-index mode is refused in compact representation.
// - Register mode returns register contents, sized byte to quadword by opcode.
// - Immediate operand comes from the instruction stream, instruction space.
// - Indirect register refuses register zero, for memory and for I/O.
// - Indirect operand sits at the register address, data or I/O by opcode.
// - Direct operand sits at instruction address, data or I/O by opcode.
// - Index mode adds instruction address and nonzero word or longword index.
// - Segmented and linear share operand location, differ only in arithmetic.
// - Word index values are sign-extended to 32 bits.
// - Short displacements sign-extend, except decrement-jump-nonzero which zero-extends.
// - Linear sums are 32-bit and wrap.
// - Segmented sums touch 16-bit or 24-bit offset only, segment kept from base.
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH
`define OAG_ADDR_W 32
`define OAG_WORD_W 16
`define OAG_LARGE_W 24
`define OAG_DATA_W 64
`define OAG_REG_W 4
`define OAG_REG_ZERO 4'h0
`endif

// *** inc/oag_pkg.sv ***
// Shared types of the operand address generator
package oag_pkg;
  typedef enum logic [1:0] {
    REPR_COMPACT = 2'h0,
    REPR_SEGMENTED = 2'h1,
    REPR_LINEAR = 2'h2
  } oag_repr_t;
  typedef enum logic [3:0] {
    MODE_REGISTER = 4'h0,
    MODE_IMMEDIATE = 4'h1,
    MODE_INDIRECT = 4'h2,
    MODE_DIRECT = 4'h3,
    MODE_INDEX = 4'h4,
    MODE_BASE = 4'h5,
    MODE_BASE_INDEX = 4'h6,
    MODE_RELATIVE = 4'h7,
    MODE_RELATIVE_INDEX = 4'h8
  } oag_mode_t;
  typedef enum logic [2:0] {
    OP_OTHER = 3'h0,
    OP_LOAD = 3'h1,
    OP_LOAD_ADDR = 3'h2,
    OP_CALL = 3'h3,
    OP_JUMP = 3'h4,
    OP_DECREMENT_JUMP_NONZERO = 3'h5
  } oag_op_t;
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2,
    SIZE_QUAD = 2'h3
  } oag_size_t;
  typedef enum logic [1:0] {
    SPACE_NONE = 2'h0,
    SPACE_DATA = 2'h1,
    SPACE_INSTR = 2'h2,
    SPACE_IO = 2'h3
  } oag_space_t;
  typedef enum logic [1:0] {
    KIND_REG = 2'h0,
    KIND_IMM = 2'h1,
    KIND_MEM = 2'h2
  } oag_kind_t;
endpackage : oag_pkg

// *** inc/oag_calc_if.sv ***
// Operand bundle between decoder and address adder
`include "oag_params.svh"
interface oag_calc_if;
  logic [`OAG_ADDR_W-1:0] base;
  logic [`OAG_ADDR_W-1:0] index;
  logic [`OAG_ADDR_W-1:0] disp;
  logic sub;
  logic large_seg;
  oag_pkg::oag_repr_t repr;
  logic [`OAG_ADDR_W-1:0] ea;
  modport calc (input base, input index, input disp, input sub, input large_seg, input repr, output ea);
  modport user (output base, output index, output disp, output sub, output large_seg, output repr, input ea);
endinterface : oag_calc_if

// *** hdl/oag_adder.sv ***
// Effective address adder with per-representation wrap
`include "oag_params.svh"
module oag_adder (
  oag_calc_if.calc c // Operands in, address out
);
  logic [`OAG_ADDR_W-1:0] sum;
  logic [`OAG_ADDR_W-1:0] ofs_cmp;
  logic [`OAG_ADDR_W-1:0] ofs_small;
  logic [`OAG_ADDR_W-1:0] ofs_large;

  // Subtracting form serves call-relative and decrement-jump-nonzero
  assign sum = c.sub ? (c.base + c.index - c.disp) : (c.base + c.index + c.disp);
  assign ofs_cmp = {{(`OAG_ADDR_W-`OAG_WORD_W){1'b0}}, sum[`OAG_WORD_W-1:0]};
  // Segment number bits always come from the base, carries die at the offset top
  assign ofs_small = {c.base[`OAG_ADDR_W-1:`OAG_WORD_W], sum[`OAG_WORD_W-1:0]};
  assign ofs_large = {c.base[`OAG_ADDR_W-1:`OAG_LARGE_W], sum[`OAG_LARGE_W-1:0]};

  assign c.ea = (c.repr == oag_pkg::REPR_COMPACT) ? ofs_cmp :
                (c.repr == oag_pkg::REPR_SEGMENTED) ? (c.large_seg ? ofs_large : ofs_small) :
                sum;
endmodule : oag_adder

// *** hdl/oag_top.sv ***
// Operand locator and effective address generator
`include "oag_params.svh"
module oag_top (
  input logic clk, // Core clock
  input logic reset_n, // Synchronous reset
  input logic clk_en, // Freezes all state when low except during reset
  input logic req_valid, // Decoded operand present
  input oag_pkg::oag_repr_t req_repr, // Address representation
  input oag_pkg::oag_mode_t req_mode, // Addressing mode
  input oag_pkg::oag_op_t req_op, // Instruction class
  input oag_pkg::oag_size_t req_size, // Register operand size
  input logic req_io, // Opcode asks for I/O space
  input logic req_idx_long, // Index is a longword register
  input logic req_large_seg, // Segmented base is a large segment
  input logic req_disp_short, // Displacement encoded in 16 bits
  input logic [`OAG_REG_W-1:0] req_base_reg, // Base register number
  input logic [`OAG_REG_W-1:0] req_idx_reg, // Index register number
  input logic [`OAG_ADDR_W-1:0] req_base_val, // Base register contents
  input logic [`OAG_ADDR_W-1:0] req_idx_val, // Index register contents
  input logic [`OAG_ADDR_W-1:0] req_disp, // Displacement or instruction address
  input logic [`OAG_ADDR_W-1:0] req_pc_next, // Address after the displacement
  input logic [`OAG_ADDR_W-1:0] req_imm, // Immediate from instruction
  input logic [`OAG_DATA_W-1:0] req_reg_val, // Register operand contents
  output logic rsp_valid, // Result present
  output oag_pkg::oag_kind_t rsp_kind, // Register, immediate or memory
  output oag_pkg::oag_space_t rsp_space, // Address space to use
  output logic [`OAG_ADDR_W-1:0] rsp_addr, // Effective address
  output logic [`OAG_DATA_W-1:0] rsp_data, // Register or immediate value
  output logic rsp_illegal // Mode refused
);

  function automatic logic reg_zero(input logic [`OAG_REG_W-1:0] r);
    reg_zero = (r == `OAG_REG_ZERO);
  endfunction : reg_zero

  oag_calc_if calc ();

  oag_adder u_adder (
    .c(calc.calc)
  );

  logic rsp_valid_ff;
  oag_pkg::oag_kind_t rsp_kind_ff;
  oag_pkg::oag_space_t rsp_space_ff;
  logic [`OAG_ADDR_W-1:0] rsp_addr_ff;
  logic [`OAG_DATA_W-1:0] rsp_data_ff;
  logic rsp_illegal_ff;

  wire is_cmp = (req_repr == oag_pkg::REPR_COMPACT);
  wire bad_repr = (req_repr != oag_pkg::REPR_COMPACT) && (req_repr != oag_pkg::REPR_SEGMENTED) &&
                  (req_repr != oag_pkg::REPR_LINEAR);
  wire m_reg = (req_mode == oag_pkg::MODE_REGISTER);
  wire m_imm = (req_mode == oag_pkg::MODE_IMMEDIATE);
  wire m_ind = (req_mode == oag_pkg::MODE_INDIRECT);
  wire m_da = (req_mode == oag_pkg::MODE_DIRECT);
  wire m_idx = (req_mode == oag_pkg::MODE_INDEX);
  wire m_base = (req_mode == oag_pkg::MODE_BASE);
  wire m_bx = (req_mode == oag_pkg::MODE_BASE_INDEX);
  wire m_rel = (req_mode == oag_pkg::MODE_RELATIVE);
  wire m_relx = (req_mode == oag_pkg::MODE_RELATIVE_INDEX);
  wire m_known = m_reg | m_imm | m_ind | m_da | m_idx | m_base | m_bx | m_rel | m_relx;

  wire op_ld = (req_op == oag_pkg::OP_LOAD) || (req_op == oag_pkg::OP_LOAD_ADDR);
  wire op_decrement_jump_nonzero = (req_op == oag_pkg::OP_DECREMENT_JUMP_NONZERO);
  wire op_rel = op_ld || op_decrement_jump_nonzero || (req_op == oag_pkg::OP_CALL) || (req_op == oag_pkg::OP_JUMP);
  wire base_zero = reg_zero(req_base_reg);
  wire idx_zero = reg_zero(req_idx_reg);

  // Short displacement widening
  wire [`OAG_ADDR_W-1:0] disp_ext = !req_disp_short ? req_disp :
    op_decrement_jump_nonzero ? {{(`OAG_ADDR_W-`OAG_WORD_W){1'b0}}, req_disp[`OAG_WORD_W-1:0]} :
    {{(`OAG_ADDR_W-`OAG_WORD_W){req_disp[`OAG_WORD_W-1]}}, req_disp[`OAG_WORD_W-1:0]};

  wire [`OAG_ADDR_W-1:0] idx_ext = req_idx_long ? req_idx_val :
    {{(`OAG_ADDR_W-`OAG_WORD_W){req_idx_val[`OAG_WORD_W-1]}}, req_idx_val[`OAG_WORD_W-1:0]};

  // Base operand of the sum per mode
  wire [`OAG_ADDR_W-1:0] sel_base = (m_rel | m_relx) ? req_pc_next :
                                    (m_da | m_idx) ? disp_ext :
                                    req_base_val;
  wire use_idx = m_idx | m_bx | m_relx;
  // Compact base-index carries no displacement
  wire use_disp = m_base | m_rel | m_relx | (m_bx & !is_cmp);

  assign calc.base = sel_base;
  assign calc.index = use_idx ? idx_ext : '0;
  assign calc.disp = use_disp ? disp_ext : '0;
  assign calc.sub = m_rel & ((req_op == oag_pkg::OP_CALL) | op_decrement_jump_nonzero);
  assign calc.large_seg = req_large_seg;
  assign calc.repr = req_repr;

  // Refusal conditions
  wire ill_ind = m_ind & base_zero;
  wire ill_idx = m_idx & idx_zero;
  wire ill_base = m_base & (base_zero | (is_cmp & !op_ld));
  wire ill_bx = m_bx & (base_zero | idx_zero | (is_cmp & !op_ld));
  wire ill_rel = m_rel & is_cmp & !op_rel;
  wire ill_relx = m_relx & (is_cmp | idx_zero);
  wire illegal = bad_repr | !m_known | ill_ind | ill_idx | ill_base | ill_bx | ill_rel | ill_relx;

  wire io_space = (m_ind | m_da) & req_io;
  // I/O addresses are one word wide
  wire [`OAG_ADDR_W-1:0] io_addr = {{(`OAG_ADDR_W-`OAG_WORD_W){1'b0}}, calc.ea[`OAG_WORD_W-1:0]};

  wire oag_pkg::oag_space_t nxt_space = illegal ? oag_pkg::SPACE_NONE :
                                        m_reg ? oag_pkg::SPACE_NONE :
                                        (m_imm | m_rel | m_relx) ? oag_pkg::SPACE_INSTR :
                                        io_space ? oag_pkg::SPACE_IO :
                                        oag_pkg::SPACE_DATA;

  wire oag_pkg::oag_kind_t nxt_kind = m_reg ? oag_pkg::KIND_REG :
                                      m_imm ? oag_pkg::KIND_IMM : oag_pkg::KIND_MEM;

  wire [`OAG_ADDR_W-1:0] nxt_addr = (illegal | m_reg | m_imm) ? '0 : io_space ? io_addr : calc.ea;

  // Register size trims the value
  wire [`OAG_DATA_W-1:0] reg_sized =
    (req_size == oag_pkg::SIZE_BYTE) ? {{(`OAG_DATA_W-8){1'b0}}, req_reg_val[7:0]} :
    (req_size == oag_pkg::SIZE_WORD) ? {{(`OAG_DATA_W-16){1'b0}}, req_reg_val[15:0]} :
    (req_size == oag_pkg::SIZE_LONG) ? {{(`OAG_DATA_W-32){1'b0}}, req_reg_val[31:0]} :
    req_reg_val;

  wire [`OAG_DATA_W-1:0] nxt_data = illegal ? '0 : m_reg ? reg_sized :
    m_imm ? {{(`OAG_DATA_W-`OAG_ADDR_W){1'b0}}, req_imm} : '0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_kind_ff <= oag_pkg::KIND_REG;
      rsp_space_ff <= oag_pkg::SPACE_NONE;
      rsp_addr_ff <= '0;
      rsp_data_ff <= '0;
      rsp_illegal_ff <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_ff <= req_valid;
      if (req_valid) begin
        rsp_kind_ff <= nxt_kind;
        rsp_space_ff <= nxt_space;
        rsp_addr_ff <= nxt_addr;
        rsp_data_ff <= nxt_data;
        rsp_illegal_ff <= illegal;
      end
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_kind = rsp_kind_ff;
  assign rsp_space = rsp_space_ff;
  assign rsp_addr = rsp_addr_ff;
  assign rsp_data = rsp_data_ff;
  assign rsp_illegal = rsp_illegal_ff;

  // Checks on the registered answer
  wire acc = clk_en & req_valid;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_answer_latency: assert property (acc |=> rsp_valid)
    else $error("Accepted request gave no answer");

  a_freeze_enable: assert property (!clk_en |=> $stable(rsp_valid) && $stable(rsp_addr) && $stable(rsp_data))
    else $error("State moved while clock enable low");

  a_base_zero_refused: assert property (acc && is_cmp && m_base && base_zero |=> rsp_illegal)
    else $error("Compact base mode accepted register zero");

  a_base_op_refused: assert property (acc && is_cmp && (m_base || m_bx) && !op_ld |=> rsp_illegal)
    else $error("Compact base mode accepted non-load instruction");

  a_bx_compact_sum: assert property (acc && is_cmp && m_bx && !illegal
    |=> rsp_addr == {16'h0, $past(req_base_val[15:0]) + $past(req_idx_val[15:0])})
    else $error("Compact base-index address wrong");

  a_rel_low_word: assert property (acc && is_cmp && m_rel && (req_op == oag_pkg::OP_LOAD) && !req_disp_short
    |=> rsp_addr[15:0] == $past(req_pc_next[15:0]) + $past(req_disp[15:0]) && rsp_addr[31:16] == 16'h0)
    else $error("Compact relative address wrong");

  a_rel_op_refused: assert property (acc && is_cmp && m_rel && (req_op == oag_pkg::OP_OTHER) |=> rsp_illegal)
    else $error("Compact relative mode accepted wrong instruction");

  a_rel_space: assert property (acc && (m_rel || m_relx) && !illegal |=> rsp_space == oag_pkg::SPACE_INSTR)
    else $error("Relative operand not in instruction space");

  a_relx_compact: assert property (acc && is_cmp && m_relx |=> rsp_illegal && rsp_space == oag_pkg::SPACE_NONE)
    else $error("Relative index accepted in compact mode");

  a_reg_byte: assert property (acc && m_reg && (req_size == oag_pkg::SIZE_BYTE) && !bad_repr
    |=> rsp_kind == oag_pkg::KIND_REG && rsp_data == {56'h0, $past(req_reg_val[7:0])})
    else $error("Register byte operand wrong");

  a_imm_space: assert property (acc && m_imm && !bad_repr
    |=> rsp_space == oag_pkg::SPACE_INSTR && rsp_data[31:0] == $past(req_imm))
    else $error("Immediate operand wrong");

  a_ind_zero: assert property (acc && m_ind && base_zero |=> rsp_illegal)
    else $error("Indirect accepted register zero");

  a_io_space: assert property (acc && (m_ind || m_da) && req_io && !illegal
    |=> rsp_space == oag_pkg::SPACE_IO && rsp_addr[31:16] == 16'h0)
    else $error("I/O operand space wrong");

  a_idx_linear: assert property (acc && (req_repr == oag_pkg::REPR_LINEAR) && m_idx && !idx_zero
    && !req_idx_long && !req_disp_short
    |=> rsp_addr == $past(req_disp) + {{16{$past(req_idx_val[15])}}, $past(req_idx_val[15:0])})
    else $error("Linear index address wrong");

  a_decrement_jump_nonzero_zero_ext: assert property (acc && (req_repr == oag_pkg::REPR_LINEAR) && m_rel && op_decrement_jump_nonzero && req_disp_short
    |=> rsp_addr == $past(req_pc_next) - {16'h0, $past(req_disp[15:0])})
    else $error("Short decrement displacement not zero-extended");

  a_seg_keep: assert property (acc && (req_repr == oag_pkg::REPR_SEGMENTED) && m_base && !req_large_seg && !illegal
    |=> rsp_addr[31:16] == $past(req_base_val[31:16]))
    else $error("Small segment number not kept");

  a_compact_wrap: assert property (acc && is_cmp && !m_reg && !m_imm |=> rsp_addr[31:16] == 16'h0)
    else $error("Compact address left 64K");

  c_rel_load: cover property (acc && is_cmp && m_rel && !illegal ##1 rsp_valid);
  c_seg_large: cover property (acc && (req_repr == oag_pkg::REPR_SEGMENTED) && req_large_seg && m_bx && !illegal);
  c_io_direct: cover property (acc && m_da && req_io ##1 rsp_space == oag_pkg::SPACE_IO);
  c_stall: cover property (acc ##1 !clk_en [*2] ##1 rsp_valid);

endmodule : oag_top

// *** dv/oag_tb.sv ***
// Self-checking bench for the operand address generator
`include "oag_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  oag_pkg::oag_repr_t req_repr = oag_pkg::REPR_COMPACT;
  oag_pkg::oag_mode_t req_mode = oag_pkg::MODE_REGISTER;
  oag_pkg::oag_op_t req_op = oag_pkg::OP_OTHER;
  oag_pkg::oag_size_t req_size = oag_pkg::SIZE_LONG;
  logic req_io = 1'b0;
  logic req_idx_long = 1'b0;
  logic req_large_seg = 1'b0;
  logic req_disp_short = 1'b0;
  logic [`OAG_REG_W-1:0] req_base_reg = 4'h0;
  logic [`OAG_REG_W-1:0] req_idx_reg = 4'h0;
  logic [`OAG_ADDR_W-1:0] req_base_val = 32'h0;
  logic [`OAG_ADDR_W-1:0] req_idx_val = 32'h0;
  logic [`OAG_ADDR_W-1:0] req_disp = 32'h0;
  logic [`OAG_ADDR_W-1:0] req_pc_next = 32'h0;
  logic [`OAG_ADDR_W-1:0] req_imm = 32'h0;
  logic [`OAG_DATA_W-1:0] req_reg_val = 64'h0;
  logic rsp_valid;
  oag_pkg::oag_kind_t rsp_kind;
  oag_pkg::oag_space_t rsp_space;
  logic [`OAG_ADDR_W-1:0] rsp_addr;
  logic [`OAG_DATA_W-1:0] rsp_data;
  logic rsp_illegal;
  int num_errors = 0;
  int n_compared = 0;

  always #12.5 clk = ~clk;

  oag_top dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid), .req_repr(req_repr),
    .req_mode(req_mode), .req_op(req_op), .req_size(req_size), .req_io(req_io), .req_idx_long(req_idx_long),
    .req_large_seg(req_large_seg), .req_disp_short(req_disp_short), .req_base_reg(req_base_reg),
    .req_idx_reg(req_idx_reg), .req_base_val(req_base_val), .req_idx_val(req_idx_val), .req_disp(req_disp),
    .req_pc_next(req_pc_next), .req_imm(req_imm), .req_reg_val(req_reg_val), .rsp_valid(rsp_valid),
    .rsp_kind(rsp_kind), .rsp_space(rsp_space), .rsp_addr(rsp_addr), .rsp_data(rsp_data),
    .rsp_illegal(rsp_illegal));

  task automatic test_done();
    $display("Compared %0d values, %0d mismatches", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic req(input oag_pkg::oag_repr_t r, input oag_pkg::oag_mode_t m, input oag_pkg::oag_op_t o,
      input logic [3:0] br, input logic [31:0] bv, input logic [3:0] ir, input logic [31:0] iv,
      input logic [31:0] d);
    req_repr = r;
    req_mode = m;
    req_op = o;
    req_base_reg = br;
    req_base_val = bv;
    req_idx_reg = ir;
    req_idx_val = iv;
    req_disp = d;
    req_io = 1'b0;
    req_idx_long = 1'b0;
    req_large_seg = 1'b0;
    req_disp_short = 1'b0;
  endtask : req

  // One request, answer one cycle later, valid drops after an idle edge
  task automatic issue();
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    chk("rsp_valid", rsp_valid, 64'h1);
    @(posedge clk);
    #1;
    chk("rsp_valid_drop", rsp_valid, 64'h0);
  endtask : issue

  task automatic exp_mem(input oag_pkg::oag_space_t s, input logic [31:0] a);
    issue();
    chk("rsp_illegal", rsp_illegal, 64'h0);
    chk("rsp_kind", rsp_kind, oag_pkg::KIND_MEM);
    chk("rsp_space", rsp_space, s);
    chk("rsp_addr", rsp_addr, a);
    chk("rsp_data", rsp_data, 64'h0);
  endtask : exp_mem

  task automatic exp_bad();
    issue();
    chk("rsp_illegal", rsp_illegal, 64'h1);
    chk("rsp_space", rsp_space, oag_pkg::SPACE_NONE);
    chk("rsp_addr", rsp_addr, 64'h0);
    chk("rsp_data", rsp_data, 64'h0);
  endtask : exp_bad

  task automatic t_reset();
    repeat (5) @(posedge clk);
    #1;
    chk("reset_valid", rsp_valid, 64'h0);
    chk("reset_addr", rsp_addr, 64'h0);
    chk("reset_space", rsp_space, oag_pkg::SPACE_NONE);
    reset_n = 1'b1;
  endtask : t_reset

  task automatic t_compact_base();
    for (int o = 0; o < 6; o++) begin
      req(oag_pkg::REPR_COMPACT, oag_pkg::MODE_BASE, oag_pkg::oag_op_t'(o), 4'h5, 32'h1234ff00, 4'h0, 32'h0,
        32'h200);
      if (o == 1 || o == 2) exp_mem(oag_pkg::SPACE_DATA, 32'h100);
      else exp_bad();
      req(oag_pkg::REPR_COMPACT, oag_pkg::MODE_BASE_INDEX, oag_pkg::oag_op_t'(o), 4'h5, 32'h1502, 4'h3,
        32'h0000fffe, 32'h55);
      if (o == 1 || o == 2) exp_mem(oag_pkg::SPACE_DATA, 32'h1500);
      else exp_bad();
    end
    req_op = oag_pkg::OP_LOAD;
    req_idx_reg = 4'h0;
    exp_bad();
    req(oag_pkg::REPR_COMPACT, oag_pkg::MODE_BASE, oag_pkg::OP_LOAD, 4'h0, 32'h20aa, 4'h0, 32'h0, 32'h18);
    exp_bad();
  endtask : t_compact_base

  // Call and decrement-jump-nonzero subtract the displacement
  task automatic t_compact_rel();
    for (int o = 0; o < 6; o++) begin
      req(oag_pkg::REPR_COMPACT, oag_pkg::MODE_RELATIVE, oag_pkg::oag_op_t'(o), 4'h0, 32'h0, 4'h0, 32'h0, 32'h2);
      req_pc_next = 32'habcd0204;
      if (o == 0) exp_bad();
      else exp_mem(oag_pkg::SPACE_INSTR, (o == 3 || o == 5) ? 32'h202 : 32'h206);
    end
    req(oag_pkg::REPR_COMPACT, oag_pkg::MODE_RELATIVE_INDEX, oag_pkg::OP_LOAD, 4'h0, 32'h0, 4'h2, 32'h2, 32'h0);
    exp_bad();
    req_mode = oag_pkg::oag_mode_t'(4'h9);
    exp_bad();
    req_repr = oag_pkg::oag_repr_t'(2'h3);
    req_mode = oag_pkg::MODE_DIRECT;
    exp_bad();
  endtask : t_compact_rel

  task automatic t_reg_imm();
    logic [63:0] mask [4] = '{64'hff, 64'hffff, 64'hffffffff, 64'hffffffffffffffff};
    for (int s = 0; s < 4; s++) begin
      req(oag_pkg::REPR_LINEAR, oag_pkg::MODE_REGISTER, oag_pkg::OP_LOAD, 4'h6, 32'h0, 4'h0, 32'h0, 32'h0);
      req_size = oag_pkg::oag_size_t'(s);
      req_reg_val = 64'h0123456789abcdef;
      issue();
      chk("reg_kind", rsp_kind, oag_pkg::KIND_REG);
      chk("reg_data", rsp_data, 64'h0123456789abcdef & mask[s]);
    end
    req(oag_pkg::REPR_SEGMENTED, oag_pkg::MODE_IMMEDIATE, oag_pkg::OP_LOAD, 4'h0, 32'h0, 4'h0, 32'h0, 32'h0);
    req_imm = 32'h55;
    issue();
    chk("imm_kind", rsp_kind, oag_pkg::KIND_IMM);
    chk("imm_space", rsp_space, oag_pkg::SPACE_INSTR);
    chk("imm_data", rsp_data, 64'h55);
  endtask : t_reg_imm

  task automatic t_indirect_direct();
    for (int r = 1; r < 3; r++) begin
      req(oag_pkg::oag_repr_t'(r), oag_pkg::MODE_INDIRECT, oag_pkg::OP_LOAD, 4'h4, 32'h0002170c, 4'h0, 32'h0, 32'h0);
      exp_mem(oag_pkg::SPACE_DATA, 32'h0002170c);
      req_io = 1'b1;
      exp_mem(oag_pkg::SPACE_IO, 32'h170c);
      req_base_reg = 4'h0;
      exp_bad();
      req_io = 1'b0;
      exp_bad();
      req(oag_pkg::oag_repr_t'(r), oag_pkg::MODE_DIRECT, oag_pkg::OP_LOAD, 4'h0, 32'h0, 4'h0, 32'h0, 32'h85000023);
      exp_mem(oag_pkg::SPACE_DATA, 32'h85000023);
      req_io = 1'b1;
      exp_mem(oag_pkg::SPACE_IO, 32'h0023);
    end
  endtask : t_indirect_direct

  task automatic t_index_wrap();
    req(oag_pkg::REPR_LINEAR, oag_pkg::MODE_INDEX, oag_pkg::OP_LOAD, 4'h0, 32'h0, 4'h7, 32'h0000fffe, 32'h100);
    exp_mem(oag_pkg::SPACE_DATA, 32'h000000fe);
    req_idx_long = 1'b1;
    exp_mem(oag_pkg::SPACE_DATA, 32'h000100fe);
    req_idx_reg = 4'h0;
    exp_bad();
    req(oag_pkg::REPR_SEGMENTED, oag_pkg::MODE_BASE, oag_pkg::OP_LOAD, 4'h4, 32'h0002fff0, 4'h0, 32'h0, 32'h20);
    exp_mem(oag_pkg::SPACE_DATA, 32'h00020010);
    req_base_val = 32'h88fffff0;
    req_large_seg = 1'b1;
    exp_mem(oag_pkg::SPACE_DATA, 32'h88000010);
    req(oag_pkg::REPR_SEGMENTED, oag_pkg::MODE_BASE_INDEX, oag_pkg::OP_LOAD, 4'h4, 32'h00025678, 4'h2,
      32'h0000ba98, 32'hffffffff);
    req_idx_long = 1'b1;
    exp_mem(oag_pkg::SPACE_DATA, 32'h0002110f);
    req_base_val = 32'h0313579b;
    req_idx_val = 32'hffffffe0;
    req_disp = 32'h2;
    req_large_seg = 1'b1;
    exp_mem(oag_pkg::SPACE_DATA, 32'h0313577d);
    req(oag_pkg::REPR_LINEAR, oag_pkg::MODE_BASE, oag_pkg::OP_LOAD, 4'h4, 32'hfffffff0, 4'h0, 32'h0, 32'h20);
    exp_mem(oag_pkg::SPACE_DATA, 32'h00000010);
    req(oag_pkg::REPR_LINEAR, oag_pkg::MODE_BASE_INDEX, oag_pkg::OP_LOAD, 4'h4, 32'h01000000, 4'h2, 32'h64,
      32'h1234ff9b);
    req_idx_long = 1'b1;
    req_disp_short = 1'b1;
    exp_mem(oag_pkg::SPACE_DATA, 32'h00ffffff);
    req(oag_pkg::REPR_LINEAR, oag_pkg::MODE_RELATIVE, oag_pkg::OP_DECREMENT_JUMP_NONZERO, 4'h0, 32'h0, 4'h0, 32'h0, 32'h0000fffe);
    req_disp_short = 1'b1;
    req_pc_next = 32'h1000;
    exp_mem(oag_pkg::SPACE_INSTR, 32'hffff1002);
  endtask : t_index_wrap

  // Back-to-back requests, then two frozen cycles
  task automatic t_pipe();
    req(oag_pkg::REPR_LINEAR, oag_pkg::MODE_DIRECT, oag_pkg::OP_LOAD, 4'h0, 32'h0, 4'h0, 32'h0, 32'h10);
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_disp = 32'h20;
    chk("b2b_addr0", rsp_addr, 64'h10);
    @(posedge clk);
    #1;
    clk_en = 1'b0;
    req_disp = 32'h30;
    chk("b2b_valid", rsp_valid, 64'h1);
    chk("b2b_addr1", rsp_addr, 64'h20);
    @(posedge clk);
    #1;
    chk("frozen_addr", rsp_addr, 64'h20);
    chk("frozen_valid", rsp_valid, 64'h1);
    @(posedge clk);
    #1;
    clk_en = 1'b1;
    req_valid = 1'b0;
    chk("frozen2_addr", rsp_addr, 64'h20);
    chk("frozen2_valid", rsp_valid, 64'h1);
    @(posedge clk);
    #1;
    chk("idle_valid", rsp_valid, 64'h0);
    chk("held_addr", rsp_addr, 64'h20);
  endtask : t_pipe

  // Reset in mid-run drops a pending answer
  task automatic t_midreset();
    req(oag_pkg::REPR_LINEAR, oag_pkg::MODE_DIRECT, oag_pkg::OP_LOAD, 4'h0, 32'h0, 4'h0, 32'h0, 32'h40);
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    reset_n = 1'b0;
    @(posedge clk);
    #1;
    chk("midreset_valid", rsp_valid, 64'h0);
    chk("midreset_addr", rsp_addr, 64'h0);
    chk("midreset_space", rsp_space, oag_pkg::SPACE_NONE);
    reset_n = 1'b1;
    exp_mem(oag_pkg::SPACE_DATA, 32'h40);
  endtask : t_midreset

  initial begin
    #1ms;
    num_errors++;
    test_done();
  end

  initial begin
    t_reset();
    t_compact_base();
    t_compact_rel();
    t_reg_imm();
    t_indirect_direct();
    t_index_wrap();
    t_pipe();
    t_midreset();
    test_done();
  end
endmodule : testbench
